/* File: rtl/flash_otp_device.sv */
// device end: otp areas, security word bank, lock words, status and special reads
//
// Contract
// - four otp areas: parameter group, three main
// - otp area rejects later program and erase
// - area map bottom blocks 0,1,2,3 or top mirror
// - seventeen security registers, each locked alone
// - first register halves: factory id, blank user
// - programmed bits never return to blank
// - unlocked register accepts repeated programs
// - one otp lock bit per upper register, two for the first
// - read id mode, one word per read
// - host programs command and data same address
// - security program one word per operation
// - program outside security space sets program fail
// - locked program: fail plus violation, no change
// - lock words at 0x80 and 0x89
// - lock word zero bit0 factory, bit1 user
// - host locks user half with 0xFFFD
// - lock word one bits lock upper registers
// - page mode: only first word valid
// - burst repeats word for burst length
// - error flags sticky until clear or reset
// - ready bit low while programming
`timescale 1ns/1ps
module flash_otp_device #(
  parameter int ADDR_W = flash_otp_pkg::ADDR_W,
  parameter bit TOP_PARAM = 1'b0,
  parameter int BURST_LEN = flash_otp_pkg::BURST_LEN,
  parameter int PROG_CYC = flash_otp_pkg::PROG_CYC,
  parameter int ERASE_CYC = flash_otp_pkg::ERASE_CYC,
  // arbitrary factory identity value
  parameter logic [63:0] UNIQUE_ID = flash_otp_pkg::UNIQUE_ID_DEFAULT
) (
  input logic mclk,
  input logic resetn,
  flash_bus_if.dev_end bus,
  input logic [flash_otp_pkg::OTP_AREAS-1:0] otp_area_set,
  output logic [flash_otp_pkg::OTP_AREAS-1:0] otp_area_q,
  output logic device_ready_q
);
  import flash_otp_pkg::*;
  localparam int BLK_W = ADDR_W - BLOCK_SHIFT;
  localparam int SW = 3 + ADDR_W + DQ_W;

  typedef struct packed {
    dev_state_t st;
    rmode_t rm;
    logic [OTP_AREAS-1:0] areas;
    logic [7:0] sr;
    logic [15:0] lock0;
    logic [15:0] lock1;
    logic [PR_WORDS-1:0][15:0] mem;
    wr_kind_t p_kind;
    logic [7:0] p_idx;
    logic [15:0] p_data;
    logic [7:0] p_err;
    logic [15:0] cnt;
    logic we_p;
    logic oe_p;
    logic bclk_p;
    logic [15:0] dq;
    logic dq_oe;
    logic [7:0] bcnt;
  } dev_regs_t;

  dev_regs_t q, d;
  logic [SW-1:0] s_all;
  logic s_ce_n, s_we_n, s_oe_n;
  logic [ADDR_W-1:0] s_addr;
  logic [DQ_W-1:0] s_dq;
  logic [ADDR_W-1:0] param_base, off;
  logic [BLK_W-1:0] blk;
  logic in_prot, locked, area_hit, we_rise, oe_fall;
  logic [7:0] idx;
  logic [15:0] rd_word;

  // every pin input crosses two flops; bclk is sampled separately below
  pin_sync #(.W(SW)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d({bus.ce_n, bus.we_n, bus.oe_n, bus.addr, bus.dq}),
    .q(s_all)
  );
  logic s_bclk;
  pin_sync #(.W(1)) u_bclk (
    .mclk(mclk),
    .resetn(resetn),
    .d(bus.bclk),
    .q(s_bclk)
  );
  assign {s_ce_n, s_we_n, s_oe_n, s_addr, s_dq} = s_all;

  // pins and user outputs straight from flops
  assign bus.dev_dq_o = q.dq;
  assign bus.dev_dq_oe = q.dq_oe;
  assign otp_area_q = q.areas;
  assign device_ready_q = q.sr[SR_READY];

  always_comb begin
    d = q;
    d.we_p = s_we_n;
    d.oe_p = s_oe_n;
    d.bclk_p = s_bclk;
    we_rise = s_we_n && !q.we_p && !s_ce_n;
    oe_fall = !s_oe_n && q.oe_p && !s_ce_n;
    // security space sits above the parameter base
    param_base = TOP_PARAM ? {{BLK_W{1'b1}}, {BLOCK_SHIFT{1'b0}}} : '0;
    off = ADDR_W'(s_addr - param_base);
    in_prot = (off >= ADDR_W'(OFS_PR0)) && (off <= ADDR_W'(OFS_PR_END)) && (off != ADDR_W'(OFS_LOCK1));
    // lock word one splits the bank, so skip its slot
    idx = 8'(off - ADDR_W'(OFS_PR0) - ((off > ADDR_W'(OFS_LOCK1)) ? ADDR_W'(1) : ADDR_W'(0)));
    // each upper register has its own lock bit, the first one per half
    if (idx < 8'(PR0_FACT_WORDS)) begin
      locked = !q.lock0[0];
    end else if (idx < 8'(PR0_WORDS)) begin
      locked = !q.lock0[1];
    end else begin
      locked = !q.lock1[4'((idx - 8'(PR0_WORDS)) >> PR_UP_SHIFT)];
    end
    // area k is block k from the bottom, or the mirror from the top
    blk = s_addr[ADDR_W-1:BLOCK_SHIFT];
    area_hit = 1'b0;
    for (int k = 0; k < OTP_AREAS; k++) begin
      if (q.areas[k] && blk == (TOP_PARAM ? BLK_W'({BLK_W{1'b1}} - BLK_W'(k)) : BLK_W'(k))) begin
        area_hit = 1'b1;
      end
    end
    // word presented by a read in the current mode
    case (q.rm)
      RM_STATUS: rd_word = {8'h00, q.sr};
      RM_ID: begin
        if (off == ADDR_W'(OFS_LOCK0)) begin
          rd_word = q.lock0;
        end else if (off == ADDR_W'(OFS_LOCK1)) begin
          rd_word = q.lock1;
        end else if (in_prot) begin
          rd_word = q.mem[idx];
        end else begin
          rd_word = 16'h0000;
        end
      end
      default: rd_word = WORD_BLANK; // array contents are not kept here
    endcase

    // areas become otp once set and stay so until reset
    d.areas = q.areas | otp_area_set;

    // command decode and operation sequencing
    case (q.st)
      DS_READY: begin
        if (we_rise) begin
          case (s_dq[7:0])
            CMD_READ_ARRAY: d.rm = RM_ARRAY;
            CMD_READ_ID: d.rm = RM_ID;
            CMD_READ_STATUS: d.rm = RM_STATUS;
            CMD_CLEAR_STATUS: d.sr = q.sr & ~SR_ERR_MASK;
            CMD_PROG_PROT: d.st = DS_PROT_DATA;
            CMD_PROG_WORD: d.st = DS_ARRAY_DATA;
            CMD_ERASE_SETUP: d.st = DS_ARRAY_DATA;
            default: d.rm = q.rm;
          endcase
          d.p_err = (s_dq[7:0] == CMD_ERASE_SETUP) ? 8'h01 : 8'h00; // marks erase pending
        end
      end
      DS_PROT_DATA: begin
        if (we_rise) begin
          d.p_idx = idx;
          d.p_data = s_dq;
          d.p_err = 8'h00;
          if (off == ADDR_W'(OFS_LOCK0)) begin
            d.p_kind = WK_LOCK0;
          end else if (off == ADDR_W'(OFS_LOCK1)) begin
            d.p_kind = WK_LOCK1;
          end else if (!in_prot) begin
            d.p_kind = WK_NONE;
            d.p_err[SR_PROG_FAIL] = 1'b1;
          end else if (locked) begin
            d.p_kind = WK_NONE;
            d.p_err[SR_PROG_FAIL] = 1'b1;
            d.p_err[SR_LOCK_VIOL] = 1'b1;
          end else begin
            d.p_kind = WK_MEM;
          end
          d.cnt = 16'(PROG_CYC);
          d.sr[SR_READY] = 1'b0;
          d.st = DS_BUSY;
          d.rm = RM_STATUS;
        end
      end
      DS_ARRAY_DATA: begin
        if (we_rise) begin
          d.p_kind = WK_NONE;
          d.rm = RM_STATUS;
          if (q.p_err[0] && s_dq[7:0] != CMD_ERASE_CONFIRM) begin
            // bad erase confirm is a sequence error, no operation runs
            d.sr = q.sr | (8'h1 << SR_ERASE_FAIL) | (8'h1 << SR_PROG_FAIL);
            d.st = DS_READY;
          end else begin
            d.p_err = 8'h00;
            if (area_hit) begin
              d.p_err[q.p_err[0] ? SR_ERASE_FAIL : SR_PROG_FAIL] = 1'b1;
              d.p_err[SR_LOCK_VIOL] = 1'b1;
            end
            d.cnt = q.p_err[0] ? 16'(ERASE_CYC) : 16'(PROG_CYC);
            d.sr[SR_READY] = 1'b0;
            d.st = DS_BUSY;
          end
        end
      end
      DS_BUSY: begin
        // writes during an operation are ignored
        d.cnt = q.cnt - 16'd1;
        if (q.cnt <= 16'd1) begin
          d.st = DS_READY;
          d.sr = q.sr | q.p_err;
          d.sr[SR_READY] = 1'b1;
          // and-ing only clears bits, so nothing returns to blank
          case (q.p_kind)
            WK_MEM: d.mem[q.p_idx] = q.mem[q.p_idx] & q.p_data;
            WK_LOCK0: d.lock0 = q.lock0 & q.p_data;
            WK_LOCK1: d.lock1 = q.lock1 & q.p_data;
            default: d.p_idx = q.p_idx;
          endcase
        end
      end
      default: d.st = DS_READY;
    endcase

    // one word latched per output enable; later page or burst beats repeat it
    if (oe_fall) begin
      d.dq = rd_word;
      d.dq_oe = 1'b1;
      d.bcnt = 8'h00;
    end else if (s_oe_n || s_ce_n) begin
      d.dq_oe = 1'b0;
    end else if (q.dq_oe && s_bclk && !q.bclk_p) begin
      d.bcnt = q.bcnt + 8'd1;
      if (q.bcnt + 8'd1 >= 8'(BURST_LEN)) begin
        d.dq_oe = 1'b0;
      end
    end

    // reset models power-up: blank bank except the factory id half
    if (!resetn) begin
      d = '0;
      d.st = DS_READY;
      d.rm = RM_ARRAY;
      d.p_kind = WK_NONE;
      d.sr = SR_RESET;
      d.lock0 = LOCK0_RESET;
      d.lock1 = LOCK1_RESET;
      d.we_p = 1'b1;
      d.oe_p = 1'b1;
      for (int w = 0; w < PR_WORDS; w++) begin
        d.mem[w] = (w < PR0_FACT_WORDS) ? UNIQUE_ID[16*w +: 16] : WORD_BLANK;
      end
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end
endmodule

/* File: rtl/flash_otp_pkg.sv */
// shared constants and types for the otp flash bus, device end and host end
package flash_otp_pkg;
  localparam int ADDR_W = 23;
  localparam int DQ_W = 16;
  localparam int BLOCK_SHIFT = 16;
  localparam int OTP_AREAS = 4;
  // command opcodes, low byte of the data bus
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_PROT = 8'hC0;
  localparam logic [7:0] CMD_PROG_WORD = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  // security space word offsets from the parameter base
  localparam logic [8:0] OFS_LOCK0 = 9'h080;
  localparam logic [8:0] OFS_PR0 = 9'h081;
  localparam logic [8:0] OFS_LOCK1 = 9'h089;
  localparam logic [8:0] OFS_PR_END = 9'h109;
  localparam int PR_WORDS = 136;
  localparam int PR0_FACT_WORDS = 4;
  localparam int PR0_WORDS = 8;
  localparam int PR_UP_SHIFT = 3;
  // status bits
  localparam int SR_READY = 7;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROG_FAIL = 4;
  localparam int SR_LOCK_VIOL = 1;
  localparam logic [7:0] SR_RESET = 8'h80;
  localparam logic [7:0] SR_ERR_MASK = 8'h3A;
  localparam logic [15:0] WORD_BLANK = 16'hFFFF;
  localparam logic [15:0] LOCK0_RESET = 16'hFFFE;
  localparam logic [15:0] LOCK1_RESET = 16'hFFFF;
  localparam logic [63:0] UNIQUE_ID_DEFAULT = 64'h1234_5678_9ABC_DEF0;
  // timing
  localparam int CLK_NS = 20;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_NS = 2000;
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_NS = 4000;
  localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BCLK_HALF_NS = 80;
  localparam int BCLK_HALF_CYC = BCLK_HALF_NS / CLK_NS;
  localparam int RD_CAP_CYC = 10;
  localparam int BURST_LEN = 4;
  typedef enum logic [3:0] {
    DS_READY = 4'b0001, DS_PROT_DATA = 4'b0010, DS_ARRAY_DATA = 4'b0100, DS_BUSY = 4'b1000
  } dev_state_t;
  typedef enum logic [2:0] {RM_ARRAY = 3'b001, RM_ID = 3'b010, RM_STATUS = 3'b100} rmode_t;
  typedef enum logic [3:0] {
    WK_NONE = 4'b0001, WK_MEM = 4'b0010, WK_LOCK0 = 4'b0100, WK_LOCK1 = 4'b1000
  } wr_kind_t;
  typedef enum logic [6:0] {
    HS_IDLE = 7'b0000001, HS_W1 = 7'b0000010, HS_G1 = 7'b0000100, HS_W2 = 7'b0001000,
    HS_G2 = 7'b0010000, HS_RD = 7'b0100000, HS_GAP = 7'b1000000
  } host_state_t;
  typedef enum logic [2:0] {PH_NONE = 3'b001, PH_WRITE = 3'b010, PH_READ = 3'b100} phase2_t;
endpackage

/* File: rtl/flash_bus_if.sv */
// parallel flash bus joining the host end and the device end
`timescale 1ns/1ps
interface flash_bus_if;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic bclk;
  logic [flash_otp_pkg::ADDR_W-1:0] addr;
  logic [flash_otp_pkg::DQ_W-1:0] host_dq_o;
  logic host_dq_oe;
  logic [flash_otp_pkg::DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [flash_otp_pkg::DQ_W-1:0] dq;
  // wire level: device wins a clash, otherwise pulled high
  assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : flash_otp_pkg::WORD_BLANK);
  modport dev_end(input ce_n, input we_n, input oe_n, input bclk, input addr, input dq,
    output dev_dq_o, output dev_dq_oe);
  modport host_end(output ce_n, output we_n, output oe_n, output bclk, output addr,
    output host_dq_o, output host_dq_oe, input dq);
endinterface

/* File: rtl/pin_sync.sv */
// two flop synchroniser, one per bit
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input logic mclk,
  input logic resetn,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        meta_q[i] <= 1'b1;
        q[i] <= 1'b1;
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule

/* File: rtl/flash_otp_host.sv */
// host end: turns user requests into strobed write and read cycles on the flash bus
`timescale 1ns/1ps
module flash_otp_host #(
  parameter int ADDR_W = flash_otp_pkg::ADDR_W,
  parameter int BURST_LEN = flash_otp_pkg::BURST_LEN
) (
  input logic mclk,
  input logic resetn,
  flash_bus_if.host_end bus,
  input logic req_valid,
  input logic [7:0] req_op,
  input logic [flash_otp_pkg::ADDR_W-1:0] req_addr,
  input logic [flash_otp_pkg::DQ_W-1:0] req_data,
  input flash_otp_pkg::phase2_t req_phase2,
  input logic req_burst,
  output logic req_ready,
  output logic rsp_valid,
  output logic [flash_otp_pkg::DQ_W-1:0] rsp_data
);
  import flash_otp_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [15:0] cnt;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic bclk;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic [DQ_W-1:0] data;
    phase2_t ph2;
    logic burst;
    logic got;
    logic [7:0] edges;
    logic ready;
    logic rsp_valid;
    logic [DQ_W-1:0] rsp_data;
  } host_regs_t;

  host_regs_t q, d;
  logic [DQ_W-1:0] s_dq;

  // read data comes back from the device domain
  pin_sync #(.W(DQ_W)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(bus.dq),
    .q(s_dq)
  );

  assign bus.ce_n = q.ce_n;
  assign bus.we_n = q.we_n;
  assign bus.oe_n = q.oe_n;
  assign bus.bclk = q.bclk;
  assign bus.addr = q.addr;
  assign bus.host_dq_o = q.dq_o;
  assign bus.host_dq_oe = q.dq_oe;
  assign req_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.cnt = q.cnt - 16'd1;
    case (q.st)
      HS_IDLE: begin
        if (req_valid && q.ready) begin
          // command and data go to the same address
          d.ready = 1'b0;
          d.addr = req_addr;
          d.data = req_data;
          d.ph2 = req_phase2;
          d.burst = req_burst;
          d.ce_n = 1'b0;
          d.we_n = 1'b0;
          d.dq_o = {8'h00, req_op};
          d.dq_oe = 1'b1;
          d.cnt = 16'(PULSE_CYC);
          d.st = HS_W1;
        end
      end
      HS_W1, HS_W2: begin
        if (q.cnt <= 16'd1) begin
          d.we_n = 1'b1;
          d.cnt = 16'(PULSE_CYC);
          d.st = (q.st == HS_W1) ? HS_G1 : HS_G2;
        end
      end
      HS_G1: begin
        // data stays driven past the rising strobe for hold time
        if (q.cnt <= 16'd1) begin
          d.dq_oe = 1'b0;
          d.cnt = 16'(PULSE_CYC);
          case (q.ph2)
            PH_WRITE: begin
              d.we_n = 1'b0;
              d.dq_o = q.data;
              d.dq_oe = 1'b1;
              d.st = HS_W2;
            end
            PH_READ: begin
              d.oe_n = 1'b0;
              d.got = 1'b0;
              d.edges = 8'h00;
              d.cnt = 16'(RD_CAP_CYC);
              d.st = HS_RD;
            end
            default: d.st = HS_G2;
          endcase
        end
      end
      HS_G2: begin
        if (q.cnt <= 16'd1) begin
          d.dq_oe = 1'b0;
          d.ce_n = 1'b1;
          d.cnt = 16'(PULSE_CYC);
          d.st = HS_GAP;
        end
      end
      HS_RD: begin
        if (q.cnt <= 16'd1) begin
          d.cnt = 16'(BCLK_HALF_CYC);
          if (!q.got) begin
            // capture the first word, then optionally run the burst clock
            d.got = 1'b1;
            d.rsp_data = s_dq;
          end else begin
            d.bclk = !q.bclk;
            d.edges = q.bclk ? q.edges : q.edges + 8'd1;
          end
          if ((q.got || !q.burst) && (!q.burst || (!q.bclk && q.edges >= 8'(BURST_LEN)))) begin
            d.bclk = 1'b0;
            d.oe_n = 1'b1;
            d.ce_n = 1'b1;
            d.cnt = 16'(PULSE_CYC);
            d.st = HS_GAP;
          end
        end
      end
      HS_GAP: begin
        if (q.cnt <= 16'd1) begin
          d.rsp_valid = 1'b1;
          d.ready = 1'b1;
          d.st = HS_IDLE;
        end
      end
      default: d.st = HS_IDLE;
    endcase
    if (!resetn) begin
      d = '0;
      d.st = HS_IDLE;
      d.ph2 = PH_NONE;
      d.ce_n = 1'b1;
      d.we_n = 1'b1;
      d.oe_n = 1'b1;
      d.ready = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end
endmodule

/* File: test/flash_bus_monitor.sv */
// protocol checker watching the flash bus between host end and device end
`timescale 1ns/1ps
module flash_bus_monitor (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic bclk,
  input wire logic [flash_otp_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_otp_pkg::DQ_W-1:0] host_dq_o,
  input wire logic host_dq_oe,
  input wire logic [flash_otp_pkg::DQ_W-1:0] dev_dq_o,
  input wire logic dev_dq_oe
);
  import flash_otp_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // the two ends never drive data at once
  a_no_bus_fight: assert property (!(dev_dq_oe && host_dq_oe))
    else $error("both ends drive the data bus");
  // device starts driving only inside a selected read
  a_drive_in_read: assert property ($rose(dev_dq_oe) |-> !oe_n && !ce_n)
    else $error("device drives data outside a read");
  // one word per read, held on every beat of page or burst
  a_read_word_held: assert property (dev_dq_oe && $past(dev_dq_oe) |-> $stable(dev_dq_o))
    else $error("read word changed while driven");
  // answer appears a few cycles after output enable falls
  a_read_answer: assert property ($fell(oe_n) && !ce_n |-> ##[2:6] dev_dq_oe)
    else $error("device did not answer a read");
  // released soon after the read ends, so the bus floats back high
  a_read_release: assert property ($rose(oe_n) |-> ##[0:5] !dev_dq_oe)
    else $error("device kept driving after the read");
  // command and data go to the same address within one selection
  a_addr_same: assert property (!ce_n && $past(!ce_n) |-> $stable(addr))
    else $error("address moved during a selection");
  // write strobe width fixed by the host pulse count
  a_write_pulse: assert property ($fell(we_n) |-> (!we_n)[*5] ##1 we_n)
    else $error("write strobe width wrong");
  // write data held and driven while the strobe is low
  a_write_data: assert property (!we_n && $past(!we_n) |-> host_dq_oe && $stable(host_dq_o))
    else $error("write data unstable under strobe");
  // burst clock only runs inside a selected read
  a_burst_clock: assert property ($rose(bclk) |-> !oe_n && !ce_n)
    else $error("burst clock outside a read");
  a_strobe_excl: assert property (we_n || oe_n)
    else $error("write and read strobes low together");
endmodule

/* File: test/tb_top.sv */
// self-checking bench: host end and device end joined on one bus
`timescale 1ns/1ps
module tb_top;
  import flash_otp_pkg::*;
  localparam int PCYC = 40;
  localparam logic [63:0] UID = 64'h0F1E_2D3C_4B5A_6978; // arbitrary identity value
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_burst = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DQ_W-1:0] req_data = 16'h0000;
  phase2_t req_phase2 = PH_NONE;
  logic [OTP_AREAS-1:0] otp_area_set = 4'h0;
  logic req_ready, rsp_valid, device_ready_q, rdy_at_rsp;
  logic [DQ_W-1:0] rsp_data, got, d1, d2;
  logic [OTP_AREAS-1:0] otp_area_q;
  logic [15:0] lfsr_q = 16'h0A1A;
  logic [ADDR_W-1:0] a;
  int n_errors = 0;
  int checks_done = 0;
  flash_bus_if flash_bus_if_inst ();
  flash_otp_host flash_otp_host_inst (.mclk(mclk), .resetn(resetn), .bus(flash_bus_if_inst),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_phase2(req_phase2), .req_burst(req_burst), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  // short busy times keep the run brief but still visible at the answer
  flash_otp_device #(.PROG_CYC(PCYC), .ERASE_CYC(PCYC), .UNIQUE_ID(UID)) flash_otp_device_inst (
    .mclk(mclk), .resetn(resetn), .bus(flash_bus_if_inst), .otp_area_set(otp_area_set),
    .otp_area_q(otp_area_q), .device_ready_q(device_ready_q));
  flash_bus_monitor flash_bus_monitor_inst (.mclk(mclk), .resetn(resetn), .ce_n(flash_bus_if_inst.ce_n),
    .we_n(flash_bus_if_inst.we_n), .oe_n(flash_bus_if_inst.oe_n), .bclk(flash_bus_if_inst.bclk),
    .addr(flash_bus_if_inst.addr), .host_dq_o(flash_bus_if_inst.host_dq_o),
    .host_dq_oe(flash_bus_if_inst.host_dq_oe), .dev_dq_o(flash_bus_if_inst.dev_dq_o),
    .dev_dq_oe(flash_bus_if_inst.dev_dq_oe));
  // clock source
  initial begin
    forever #10 mclk = ~mclk;
  end
  function automatic logic [ADDR_W-1:0] ofs(input int o);
    return ADDR_W'(o);
  endfunction
  // expected status word, upper byte always zero
  function automatic logic [15:0] exp_sr(input logic pf, input logic ef, input logic lv);
    logic [7:0] s;
    s = SR_RESET;
    s[SR_PROG_FAIL] = pf;
    s[SR_ERASE_FAIL] = ef;
    s[SR_LOCK_VIOL] = lv;
    return {8'h00, s};
  endfunction
  // next value of the stimulus shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic rnd;
    lfsr_q = lfsr_next(lfsr_q);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one request on the user port; waits for the answer, then for the device to idle
  task automatic xfer(input logic [7:0] op, input logic [ADDR_W-1:0] ad, input logic [15:0] d,
      input phase2_t ph, input logic bu);
    int i;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= ad;
    req_data <= d;
    req_phase2 <= ph;
    req_burst <= bu;
    @(posedge mclk);
    req_valid <= 1'b0;
    for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge mclk);
    got = rsp_data;
    rdy_at_rsp = device_ready_q;
    for (i = 0; i < 200 && device_ready_q !== 1'b1; i++) @(negedge mclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic bu);
    xfer(CMD_READ_ID, ad, 16'h0000, PH_READ, bu);
  endtask
  task automatic prog(input logic [7:0] op, input logic [ADDR_W-1:0] ad, input logic [15:0] d);
    xfer(op, ad, d, PH_WRITE, 1'b0);
    chk("ready_busy", {15'h0000, rdy_at_rsp}, 16'h0000);
    chk("ready_done", {15'h0000, device_ready_q}, 16'h0001);
  endtask
  // status read, then compare with the expected flags
  task automatic stat_is(input logic pf, input logic ef, input logic lv);
    xfer(CMD_READ_STATUS, ofs(0), 16'h0000, PH_READ, 1'b0);
    chk("status", got, exp_sr(pf, ef, lv));
  endtask
  task automatic clr;
    xfer(CMD_CLEAR_STATUS, ofs(0), 16'h0000, PH_NONE, 1'b0);
  endtask
  // hang guard, well beyond the expected run length
  initial begin
    #(60000 * 20);
    n_errors++;
    end_sim;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(ofs(OFS_LOCK0), 1'b0);
    chk("lock0_reset", got, LOCK0_RESET);
    rd(ofs(OFS_LOCK1), 1'b0);
    chk("lock1_reset", got, LOCK1_RESET);
    for (int i = 0; i < PR0_WORDS; i++) begin
      rd(ofs(OFS_PR0 + i), i[0]);
      chk("pr0_word", got, (i < PR0_FACT_WORDS) ? UID[16*i +: 16] : WORD_BLANK);
    end
    stat_is(1'b0, 1'b0, 1'b0);
    // two passes on one user word: bits only ever clear
    rnd;
    a = ofs(OFS_PR0 + PR0_FACT_WORDS + lfsr_q[1:0]);
    d1 = lfsr_q;
    prog(CMD_PROG_PROT, a, d1);
    xfer(8'h00, a, 16'h0000, PH_READ, 1'b0);
    chk("status_after_prog", got, exp_sr(1'b0, 1'b0, 1'b0));
    rnd;
    d2 = lfsr_q;
    prog(CMD_PROG_PROT, a, d2);
    rd(a, 1'b0);
    chk("pr0_user", got, d1 & d2);
    // outside the security space, flags stay until cleared
    for (int i = 0; i < 2; i++) begin
      prog(CMD_PROG_PROT, ofs(i ? OFS_PR_END + 1 : OFS_LOCK0 - 1), 16'h0000);
      stat_is(1'b1, 1'b0, 1'b0);
      prog(CMD_PROG_PROT, ofs(OFS_PR_END), 16'hFFFF);
      stat_is(1'b1, 1'b0, 1'b0);
      clr;
      stat_is(1'b0, 1'b0, 1'b0);
    end
    // lock the user half, then both halves refuse programs
    prog(CMD_PROG_PROT, ofs(OFS_LOCK0), 16'hFFFD);
    prog(CMD_PROG_PROT, ofs(OFS_LOCK0), 16'hFFFF);
    rd(ofs(OFS_LOCK0), 1'b0);
    chk("lock0_user", got, 16'hFFFC);
    for (int i = 0; i < 2; i++) begin
      prog(CMD_PROG_PROT, a - ofs(i * PR0_FACT_WORDS), 16'h0000);
      stat_is(1'b1, 1'b0, 1'b1);
      clr;
    end
    rd(a, 1'b0);
    chk("pr0_unchanged", got, d1 & d2);
    // one bit of lock word one locks exactly one upper register
    rnd;
    d1 = ~(16'h0001 << lfsr_q[3:0]);
    prog(CMD_PROG_PROT, ofs(OFS_LOCK1), d1);
    rd(ofs(OFS_LOCK1), 1'b0);
    chk("lock1_set", got, d1);
    for (int i = 0; i < 16; i++) begin
      rnd;
      a = ofs(OFS_LOCK1 + 1 + (i << PR_UP_SHIFT) + lfsr_q[2:0]);
      prog(CMD_PROG_PROT, a, lfsr_q);
      stat_is(!d1[i], 1'b0, !d1[i]);
      rd(a, 1'b0);
      chk("upper_reg", got, d1[i] ? lfsr_q : WORD_BLANK);
      clr;
    end
    // a main block outside the areas still programs
    prog(CMD_PROG_WORD, ofs(OTP_AREAS << BLOCK_SHIFT), 16'h0000);
    stat_is(1'b0, 1'b0, 1'b0);
    // each otp area refuses program and erase
    for (int k = 0; k < OTP_AREAS; k++) begin
      @(posedge mclk);
      otp_area_set <= OTP_AREAS'(1 << k);
      rnd;
      a = ofs((k << BLOCK_SHIFT) + lfsr_q);
      prog(CMD_PROG_WORD, a, 16'h0000);
      chk("area_mask", 16'(otp_area_q), 16'((2 << k) - 1));
      stat_is(1'b1, 1'b0, 1'b1);
      clr;
      prog(CMD_ERASE_SETUP, a, {8'h00, CMD_ERASE_CONFIRM});
      stat_is(1'b0, 1'b1, 1'b1);
      clr;
    end
    end_sim;
  end
endmodule
